// ### common/usd_params.svh
`ifndef USD_PARAMS_SVH
`define USD_PARAMS_SVH
// ==========================================================
// register word indexes (byte address = index * 4)
`define USD_IDX_FLAG1    3'h0
`define USD_IDX_FLAG2    3'h1
`define USD_IDX_EN2      3'h2
`define USD_IDX_VEC2     3'h3
`define USD_IDX_TRIG     3'h4
`define USD_IDX_BUF_LO   3'h5
`define USD_IDX_BUF_HI   3'h6
// ==========================================================
// field positions
`define USD_BIT_SETUP    3
`define USD_BIT_VBUSCHG  0
`define USD_BIT_INTR_SENT 1
`define USD_BIT_INTR_REQ  2
`define USD_BIT_VBUSMON  3
`define USD_BIT_RDDONE   2
// ==========================================================
// reset values
`define USD_RST_EN2      3'h0
`define USD_RST_VEC2     8'h00
// ==========================================================
// setup packet layout and standard request codes
`define USD_SETUP_LEN    4'h8
`define USD_REQ_GET_DESC 8'h06
`define USD_REQ_SET_DESC 8'h07
`define USD_REQ_SYNCH    8'h0c
`define USD_REQ_MAX_STD  8'h0c
// ==========================================================
// axi responses
`define USD_RESP_OKAY    2'h0
`define USD_RESP_SLVERR  2'h2
`endif

// ### common/usd_pkg.sv
package usd_pkg;
  // ==========================================================
  // control transfer sequencing
  typedef enum logic [2:0] {
    CT_IDLE,     // no setup seen
    CT_RX,       // setup bytes arriving
    CT_AUTO,     // engine runs data and status stages
    CT_FW_WAIT,  // firmware must read the buffer, data stage naks
    CT_FW_GO     // firmware released the data stage
  } usd_ctrl_t;
endpackage : usd_pkg

// ### design/usd_req_sort.sv
`timescale 1ns/100ps
`include "usd_params.svh"
module usd_req_sort import usd_pkg::*; (
  // setup header fields
  input  wire logic [7:0] req_type,   // request type byte
  input  wire logic [7:0] req_code,   // request code byte
  // verdict
  output logic            fw_needed   // firmware must decode
);
  // ==========================================================
  // classification
  logic std_req;  // type field says standard
  always_comb begin
    std_req = (req_type[6:5] == 2'h0);
    // class and vendor requests always go up
    fw_needed = !std_req;
    // descriptors and frame sync are left to firmware
    if (std_req && (req_code == `USD_REQ_GET_DESC ||
                    req_code == `USD_REQ_SET_DESC ||
                    req_code == `USD_REQ_SYNCH)) begin
      fw_needed = 1'b1;
    end
    // unknown standard codes are safer in firmware
    if (std_req && req_code > `USD_REQ_MAX_STD) begin
      fw_needed = 1'b1;
    end
  end
endmodule : usd_req_sort

// ### design/usd_setup_dispatch.sv
`timescale 1ns/100ps
`include "usd_params.svh"
// Overview of operation
// - unmasked second-group flag raises cpu interrupt
// - vector select register supplies interrupt vector
// - enable register eight bits, low three writable
// - class and vendor requests go to firmware
// - handled requests complete data and status stages
// - firmware requests stored in setup buffer
// - firmware request received sets setup flag
// - eight byte buffer always takes new setup
// - setup flag is first flag register bit3
// - power change, ep3 acked, ep3 empty flags
// - data stage naks until read-done trigger
module usd_setup_dispatch import usd_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [4:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [4:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // setup packet from the serial engine
  input  wire logic        rx_setup_start,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_setup_ok,
  // interrupt endpoint events from the serial engine
  input  wire logic        ep3_in_nodata,
  input  wire logic        ep3_acked,
  // automatic request completion from the serial engine
  input  wire logic        auto_done,
  // bus power pin, asynchronous
  input  wire logic        vbus_pin,
  // outputs toward engine and cpu
  output logic             auto_go,
  output logic [7:0]       auto_code,
  output logic             dstage_nak,
  output logic             setup_pending,
  output logic             irq,
  output logic [7:0]       irq_vector
);
  // ==========================================================
  // state
  typedef struct packed {
    logic            awready;   // write address slot free
    logic            wready;    // write data slot free
    logic [2:0]      aw_idx;    // captured write index
    logic            aw_bad;    // write address unmapped
    logic [7:0]      wdat;      // captured write data
    logic            wlane;     // low byte lane enabled
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [2:0]      rd_idx;    // index of the read in flight
    usd_ctrl_t       ctrl;      // control transfer phase
    logic [3:0]      cnt;       // setup bytes received
    logic [7:0][7:0] buf8;      // setup receive buffer
    logic            flag_setup;
    logic [2:0]      flag2;     // second flag group
    logic [2:0]      en2;       // second enable group
    logic [7:0]      vec;       // second vector select
    logic            vb_m;      // vbus synchroniser, first stage
    logic            vb_s;      // vbus synchroniser, second stage
    logic            vb_d;      // previous synchronised level
    logic            auto_go;
    logic [7:0]      auto_code;
    logic            nak;
    logic            irq;
  } usd_state_t;

  usd_state_t s;       // registered state
  usd_state_t next_s;  // next state
  logic       fw_need;  // classifier verdict on the buffer
  logic       do_wr;    // both write halves held, no response out
  logic       ev_vbus;  // bus power level changed
  logic [2:0] ar_idx;   // read index of the current request
  logic [31:0] rd_word;
  logic       rd_bad;

  // ==========================================================
  // request classifier on the stored header
  usd_req_sort u_sort (
    .req_type  (s.buf8[0]),
    .req_code  (s.buf8[1]),
    .fw_needed (fw_need)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    next_s      = s;
    next_s.auto_go = 1'b0;
    ar_idx      = araddr[4:2];
    rd_word     = 32'h0000_0000;
    rd_bad      = 1'b0;
    // pin passes two flops before anything looks at it
    next_s.vb_m = vbus_pin;
    next_s.vb_s = s.vb_m;
    next_s.vb_d = s.vb_s;
    ev_vbus     = s.vb_s ^ s.vb_d;

    // write address and data are taken in either order
    if (awvalid && s.awready) begin
      next_s.awready = 1'b0;
      next_s.aw_idx  = awaddr[4:2];
      next_s.aw_bad  = (awaddr[4:2] > `USD_IDX_BUF_HI);
    end
    if (wvalid && s.wready) begin
      next_s.wready = 1'b0;
      next_s.wdat   = wdata[7:0];
      next_s.wlane  = wstrb[0];
    end
    do_wr = !s.awready && !s.wready && !s.bvalid;
    if (do_wr) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = s.aw_bad ? `USD_RESP_SLVERR : `USD_RESP_OKAY;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    // register writes; clears come first so that events below win
    if (do_wr && s.wlane) begin
      unique case (s.aw_idx)
        `USD_IDX_FLAG1: begin
          if (s.wdat[`USD_BIT_SETUP]) next_s.flag_setup = 1'b0;
        end
        `USD_IDX_FLAG2: begin
          next_s.flag2 = s.flag2 & ~s.wdat[2:0];
        end
        `USD_IDX_EN2: begin
          // only the low three bits hold state
          next_s.en2 = s.wdat[2:0];
        end
        `USD_IDX_VEC2: begin
          next_s.vec = s.wdat;
        end
        `USD_IDX_TRIG: begin
          // firmware has read the buffer: release the data stage
          if (s.wdat[`USD_BIT_RDDONE] && s.ctrl == CT_FW_WAIT) begin
            next_s.ctrl = CT_FW_GO;
          end
        end
        default: begin
        end
      endcase
    end

    // read mux
    unique case (ar_idx)
      `USD_IDX_FLAG1:  rd_word[`USD_BIT_SETUP] = s.flag_setup;
      `USD_IDX_FLAG2:  rd_word = {28'h0, s.vb_s, s.flag2};
      `USD_IDX_EN2:    rd_word = {29'h0, s.en2};
      `USD_IDX_VEC2:   rd_word = {24'h0, s.vec};
      `USD_IDX_TRIG:   rd_word = 32'h0000_0000;
      `USD_IDX_BUF_LO: rd_word = s.buf8[3:0];
      `USD_IDX_BUF_HI: rd_word = s.buf8[7:4];
      default:         rd_bad  = 1'b1;
    endcase
    // a buffer read during reception gets an error, not torn data
    if ((ar_idx == `USD_IDX_BUF_LO || ar_idx == `USD_IDX_BUF_HI) &&
        (s.ctrl == CT_RX || rx_setup_start)) begin
      rd_bad  = 1'b1;
      rd_word = 32'h0000_0000;
    end
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rdata   = rd_word;
      next_s.rresp   = rd_bad ? `USD_RESP_SLVERR : `USD_RESP_OKAY;
      next_s.rd_idx  = ar_idx;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end

    // control transfer sequencing
    unique case (s.ctrl)
      CT_RX: begin
        // bytes land in order; extra bytes are dropped
        if (rx_byte_valid && s.cnt < `USD_SETUP_LEN) begin
          next_s.buf8[s.cnt[2:0]] = rx_byte;
          next_s.cnt = s.cnt + 4'h1;
        end
        if (rx_setup_ok) begin
          if (s.cnt != `USD_SETUP_LEN) begin
            // short packet: nothing to act on
            next_s.ctrl = CT_IDLE;
          end else if (fw_need) begin
            next_s.ctrl       = CT_FW_WAIT;
            next_s.flag_setup = 1'b1;
          end else begin
            // engine answers on its own, no setup flag
            next_s.ctrl      = CT_AUTO;
            next_s.auto_go   = 1'b1;
            next_s.auto_code = s.buf8[1];
          end
        end
      end
      CT_AUTO: begin
        if (auto_done) next_s.ctrl = CT_IDLE;
      end
      CT_IDLE, CT_FW_WAIT, CT_FW_GO: begin
      end
    endcase
    // a new setup always wins, from any phase
    if (rx_setup_start) begin
      next_s.ctrl = CT_RX;
      next_s.cnt  = 4'h0;
      next_s.auto_go = 1'b0;
    end

    // second-group events set after clears, so set wins
    if (ev_vbus)       next_s.flag2[`USD_BIT_VBUSCHG] = 1'b1;
    if (ep3_acked)     next_s.flag2[`USD_BIT_INTR_SENT] = 1'b1;
    if (ep3_in_nodata) next_s.flag2[`USD_BIT_INTR_REQ]  = 1'b1;

    next_s.nak = (next_s.ctrl == CT_FW_WAIT);
    next_s.irq = |(next_s.flag2 & next_s.en2);
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
      s.ctrl    <= CT_IDLE;
      s.en2     <= `USD_RST_EN2;
      s.vec     <= `USD_RST_VEC2;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign awready       = s.awready;
  assign wready        = s.wready;
  assign bvalid        = s.bvalid;
  assign bresp         = s.bresp;
  assign arready       = s.arready;
  assign rvalid        = s.rvalid;
  assign rdata         = s.rdata;
  assign rresp         = s.rresp;
  assign auto_go       = s.auto_go;
  assign auto_code     = s.auto_code;
  assign dstage_nak    = s.nak;
  assign setup_pending = s.flag_setup;
  assign irq           = s.irq;
  assign irq_vector    = s.vec;

  // ==========================================================
  // assertions
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(s.flag2 & s.en2))
    else $error("irq does not follow enabled flags");

  a_vec_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && s.wlane && s.aw_idx == `USD_IDX_VEC2)
      |=> irq_vector == $past(s.wdat))
    else $error("vector select not taken");

  a_en_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && s.rd_idx == `USD_IDX_EN2) |-> rdata[31:3] == 29'h0)
    else $error("enable reserved bits not zero");

  a_fw_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.ctrl == CT_RX && rx_setup_ok && !rx_setup_start &&
     s.cnt == `USD_SETUP_LEN && fw_need)
      |=> setup_pending && dstage_nak)
    else $error("firmware request did not flag");

  a_auto_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    auto_go |-> !$rose(setup_pending) && s.ctrl == CT_AUTO)
    else $error("automatic request raised setup flag");

  a_buf_store: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.ctrl == CT_RX && rx_byte_valid && !rx_setup_start &&
     s.cnt < `USD_SETUP_LEN)
      |=> s.buf8[$past(s.cnt[2:0])] == $past(rx_byte))
    else $error("setup byte not stored");

  a_new_setup: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_setup_start |=> s.ctrl == CT_RX && s.cnt == 4'h0)
    else $error("new setup not accepted");

  a_nak_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.ctrl == CT_FW_WAIT) |-> dstage_nak)
    else $error("data stage not naked");

  a_vbus_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_vbus |=> s.flag2[`USD_BIT_VBUSCHG])
    else $error("power change not flagged");

endmodule : usd_setup_dispatch

// ### tb/usd_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// serial engine and host side of the setup path
module usd_host_model (
  // clock
  input  wire logic aclk,
  // setup packet toward the block
  output logic       rx_setup_start,
  output logic       rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic       rx_setup_ok,
  // endpoint and power events
  output logic       ep3_in_nodata,
  output logic       ep3_acked,
  output logic       vbus_pin,
  // automatic request handshake
  input  wire logic  auto_go,
  output logic       auto_done
);
  int done_wait = 1; // cycles before the stages finish
  int cnt       = 0; // countdown to auto_done
  initial begin
    {rx_setup_start, rx_byte_valid, rx_setup_ok} = 3'h0;
    {ep3_in_nodata, ep3_acked, vbus_pin} = 3'h0;
    rx_byte = 8'h00;
  end
  // stages of an automatic request end after done_wait cycles
  always @(posedge aclk) begin
    auto_done <= (cnt == 1);
    if (auto_go) begin
      cnt <= done_wait;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // one setup packet, byte 0 in pkt[7:0], gap idle cycles per byte
  task automatic send_setup(input logic [63:0] pkt, input int gap);
    int i;
    @(posedge aclk);
    rx_setup_start <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge aclk);
      rx_setup_start <= 1'b0;
      rx_byte_valid  <= 1'b1;
      rx_byte        <= pkt[8*i +: 8];
      repeat (gap) begin
        @(posedge aclk);
        rx_byte_valid <= 1'b0;
        rx_byte       <= ~rx_byte; // released line does not hold its value
      end
    end
    @(posedge aclk);
    rx_byte_valid <= 1'b0;
    rx_byte       <= ~rx_byte;
    rx_setup_ok   <= 1'b1;
    @(posedge aclk);
    rx_setup_ok   <= 1'b0;
  endtask : send_setup
  // 1: packet acked, 2: in token without data, 3: power pin edge
  task automatic pulse(input int which);
    @(posedge aclk);
    ep3_acked     <= (which == 1);
    ep3_in_nodata <= (which == 2);
    if (which == 3) begin
      vbus_pin <= ~vbus_pin;
    end
    @(posedge aclk);
    ep3_acked     <= 1'b0;
    ep3_in_nodata <= 1'b0;
  endtask : pulse
endmodule : usd_host_model

// ### tb/usd_setup_dispatch_test.sv
`timescale 1ns/100ps
`include "usd_params.svh"
module usd_setup_dispatch_test;
  logic aclk = 0, aresetn = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [4:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, auto_go, dstage_nak, setup_pending, irq;
  logic [1:0]  bresp, rresp, last_bresp;
  logic [31:0] rdata;
  logic [7:0]  auto_code, irq_vector, rx_byte;
  logic rx_setup_start, rx_byte_valid, rx_setup_ok, ep3_in_nodata, ep3_acked, auto_done;
  logic vbus_pin;
  int fails = 0, num_checks = 0, cyc = 0;
  always #4 aclk = ~aclk;
  usd_setup_dispatch u_usd_setup_dispatch (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .awvalid        (awvalid),
    .awready        (awready),
    .awaddr         (awaddr),
    .wvalid         (wvalid),
    .wready         (wready),
    .wdata          (wdata),
    .wstrb          (wstrb),
    .bvalid         (bvalid),
    .bready         (bready),
    .bresp          (bresp),
    .arvalid        (arvalid),
    .arready        (arready),
    .araddr         (araddr),
    .rvalid         (rvalid),
    .rready         (rready),
    .rdata          (rdata),
    .rresp          (rresp),
    .rx_setup_start (rx_setup_start),
    .rx_byte_valid  (rx_byte_valid),
    .rx_byte        (rx_byte),
    .rx_setup_ok    (rx_setup_ok),
    .ep3_in_nodata  (ep3_in_nodata),
    .ep3_acked      (ep3_acked),
    .auto_done      (auto_done),
    .vbus_pin       (vbus_pin),
    .auto_go        (auto_go),
    .auto_code      (auto_code),
    .dstage_nak     (dstage_nak),
    .setup_pending  (setup_pending),
    .irq            (irq),
    .irq_vector     (irq_vector)
  );
  usd_host_model u_usd_host_model (
    .aclk           (aclk),
    .rx_setup_start (rx_setup_start),
    .rx_byte_valid  (rx_byte_valid),
    .rx_byte        (rx_byte),
    .rx_setup_ok    (rx_setup_ok),
    .ep3_in_nodata  (ep3_in_nodata),
    .ep3_acked      (ep3_acked),
    .vbus_pin       (vbus_pin),
    .auto_go        (auto_go),
    .auto_done      (auto_done)
  );
  // ==========================================================
  // verdict and hang guard
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ==========================================================
  // axi4-lite master, waits as long as the slave needs
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata  <= d;
    wstrb  <= 4'hf;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_bresp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    araddr  <= a;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(5'h08, d, r); chk(d, 32'h0);
    wr(5'h08, 32'hff); rd(5'h08, d, r); chk(d, 32'h07);
    chk(last_bresp, `USD_RESP_OKAY);
    wr(5'h0c, 32'h5a); repeat (2) @(negedge aclk); chk(irq_vector, 8'h5a);
    rd(5'h1c, d, r); chk(r, `USD_RESP_SLVERR);
    wr(5'h1c, 32'h1); chk(last_bresp, `USD_RESP_SLVERR);
    wr(5'h08, 32'h0);
  endtask : t_regs
  // mid-run reset brings enables and vector back to zero
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    wr(5'h08, 32'h7);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(5'h08, d, r); chk(d, 32'h0);
    chk(irq_vector, 8'h00);
    chk(setup_pending, 1'b0);
  endtask : t_reset
  // buffer read while a new setup arrives is refused
  task automatic t_busy;
    logic [31:0] d;
    logic [1:0]  r;
    fork
      u_usd_host_model.send_setup(64'h1111_2222_3333_0680, 0);
      begin
        repeat (3) @(posedge aclk);
        rd(5'h14, d, r);
        chk(r, `USD_RESP_SLVERR);
        chk(d, 32'h0);
      end
    join
  endtask : t_busy
  // firmware-routed request: flag, buffer, nak until read-done
  task automatic t_fw(input logic [63:0] pkt, input int gap);
    logic [31:0] d;
    logic [1:0]  r;
    u_usd_host_model.send_setup(pkt, gap);
    repeat (3) @(negedge aclk);
    chk(setup_pending, 1'b1);
    chk(dstage_nak, 1'b1);
    rd(5'h00, d, r); chk(d[3], 1'b1);
    rd(5'h14, d, r); chk(d, pkt[31:0]);
    rd(5'h18, d, r); chk(d, pkt[63:32]);
    wr(5'h10, 32'h4); repeat (2) @(negedge aclk); chk(dstage_nak, 1'b0);
    wr(5'h00, 32'h8); rd(5'h00, d, r); chk(d[3], 1'b0);
  endtask : t_fw
  // automatic request: engine runs, no setup flag
  task automatic t_auto(input logic [7:0] c);
    logic go;
    logic [7:0] code;
    go = 1'b0;
    code = 8'h00;
    u_usd_host_model.send_setup({48'h0, c, 8'h00}, 0);
    repeat (6) begin
      @(negedge aclk);
      if (auto_go === 1'b1) begin
        go = 1'b1;
        code = auto_code;
      end
    end
    chk(go, 1'b1);
    chk(code, c);
    chk(setup_pending, 1'b0);
    chk(dstage_nak, 1'b0);
  endtask : t_auto
  // second flag group and its enable gating
  task automatic t_irq;
    logic [31:0] d;
    logic [1:0]  r;
    wr(5'h08, 32'h7);
    u_usd_host_model.pulse(1);
    rd(5'h04, d, r); chk(d[2:0], 3'b010);
    chk(irq, 1'b1);
    wr(5'h08, 32'h0); repeat (2) @(negedge aclk); chk(irq, 1'b0);
    wr(5'h04, 32'h2);
    u_usd_host_model.pulse(2);
    rd(5'h04, d, r); chk(d[2:0], 3'b100);
    wr(5'h04, 32'h4);
    u_usd_host_model.pulse(3);
    repeat (5) @(negedge aclk);
    rd(5'h04, d, r); chk(d[3:0], 4'b1001);
    wr(5'h08, 32'h1); repeat (2) @(negedge aclk); chk(irq, 1'b1);
    wr(5'h04, 32'h1); repeat (2) @(negedge aclk); chk(irq, 1'b0);
  endtask : t_irq
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_reset();
    t_fw(64'h0012_0000_0100_0680, 0);
    t_fw(64'h0000_0000_0000_0780, 2);
    t_fw(64'h0002_0001_0000_0c82, 0);
    t_fw(64'h0001_0000_0000_0140, 1);
    t_fw(64'h0000_0000_0000_0921, 0);
    u_usd_host_model.done_wait = 4;
    t_auto(8'h00);
    t_auto(8'h01);
    t_auto(8'h03);
    t_auto(8'h05);
    t_auto(8'h08);
    t_auto(8'h09);
    t_auto(8'h0a);
    t_auto(8'h0b);
    t_busy();
    t_fw(64'h5555_6666_7777_0680, 0);
    t_irq();
    finish_test();
  end
endmodule : usd_setup_dispatch_test
